// >>> logic/hsc_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the quad hot-swap port controller.
  Assumes a 100 MHz APB clock; all delays are counted in ticks of one internal timebase.
*/
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

// Clock and timebase
`define CLK_PERIOD_NS     10
`define TICK_NS           100000
`define TICK_CYCLES       (`TICK_NS / `CLK_PERIOD_NS)

// Delays in microseconds, and their tick counts
`define TICK_US           100
`define TON_DEL_US        25600
`define TOFF_DEL_US       3200
`define TO_DEFAULT_US     6400
`define OPEN_DEL_US       900000
`define TON_DEL_TICKS     9'((`TON_DEL_US) / (`TICK_US))
`define TOFF_DEL_TICKS    9'((`TOFF_DEL_US) / (`TICK_US))
`define TO_DEFAULT_TICKS  16'((`TO_DEFAULT_US) / (`TICK_US))
`define OPEN_DEL_TICKS    14'((`OPEN_DEL_US) / (`TICK_US))

// Off-time multipliers: off = on * (100 / duty - 1)
`define OFF_MULT_1PCT     7'h63
`define OFF_MULT_2PCT     7'h31
`define OFF_MULT_4PCT     7'h18

// Off-time select encodings
`define OFFSEL_LOW        2'h0
`define OFFSEL_HIGH       2'h1

// Register map (byte addresses)
`define ADDR_CTRL         12'h000
`define ADDR_STATUS       12'h004

// Control register fields
`define CTRL_STATSEL_BIT  0
`define CTRL_OPENEN_BIT   1
`define CTRL_RETRY_BIT    2
`define CTRL_OFFSEL_LSB   3
`define CTRL_OFFSEL_MSB   4
`define CTRL_TO_LSB       8
`define CTRL_TO_MSB       15
`define CTRL_RESET        32'h0000_0000

`endif

// >>> logic/hsc_pkg.sv
/*
  Types for the quad hot-swap port controller: per-port state and the whole-block state record.
  Assumes hsc_defines.svh is not needed here; widths are fixed by the block.
*/
package hsc_pkg;

  typedef enum logic [1:0] {
    RLY_IDLE  = 2'b00,
    RLY_ARM   = 2'b01,
    RLY_READY = 2'b10,
    RLY_DROP  = 2'b11
  } rly_phase_type;

  typedef enum logic [1:0] {
    SW_OFF   = 2'b00,
    SW_ON    = 2'b01,
    SW_OCOFF = 2'b10,
    SW_OPEN  = 2'b11
  } sw_state_type;

  typedef struct packed {
    rly_phase_type rly;
    logic [8:0]    rly_cnt;
    sw_state_type  sw;
    logic [15:0]   sw_cnt;
    logic [13:0]   open_cnt;
    logic          cleared;
    logic          sw_req_q;
  } port_type;

  typedef struct packed {
    logic [20:0]       sync1;
    logic [20:0]       sync2;
    logic [13:0]       tick_cnt;
    logic              tick;
    logic              stat_sel;
    logic              open_en;
    logic              retry_en;
    logic [1:0]        off_sel;
    logic [7:0]        to_set;
    logic [31:0]       prdata;
    port_type [3:0]    ports;
    logic [3:0]        gate;
    logic [3:0]        relay_drv;
    logic [3:0]        status;
    logic              fault_n;
  } state_type;

endpackage

// >>> logic/quad_hot_swap_port_control.sv
/*
  Control logic of a four-port hot-swap controller with an APB register slave.
  Assumes analog comparator results arrive as plain inputs in any clock relation, and that the
  relay and switch request pins come from a host controller.
*/
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "hsc_defines.svh"

module quad_hot_swap_port_control #(
  parameter int unsigned TICK_CYCLES      = `TICK_CYCLES,
  parameter bit          RELAY_ACTIVE_LOW = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  relay_request,
  input  wire logic [3:0]  switch_request,
  input  wire logic [3:0]  overcurrent,
  input  wire logic [3:0]  open_load_detect,
  input  wire logic [3:0]  output_near_supply,
  input  wire logic        supply_low_lockout,
  output logic      [3:0]  gate_enable,
  output logic      [3:0]  relay_drive,
  output logic      [3:0]  port_status,
  output logic             fault_n
);
  import hsc_pkg::*;

  state_type   s_r;
  state_type   s_nxt;
  logic [3:0]  rly_s;
  logic [3:0]  sw_s;
  logic [3:0]  oc_s;
  logic [3:0]  openl_s;
  logic [3:0]  near_s;
  logic        uv_s;
  logic [3:0]  power_good;
  logic [3:0]  open_load_latched;
  logic [3:0]  port_fault;
  logic [15:0] to_lim;
  logic [15:0] off_lim;
  logic        addr_ok;

  // Off period in ticks for the selected duty cycle; unconnected reads as neither low nor high
  function automatic logic [15:0] off_ticks(input logic [1:0] sel, input logic [15:0] on_ticks);
    logic [6:0]  mult;
    logic [22:0] prod;
    case (sel)
      `OFFSEL_LOW:  mult = `OFF_MULT_1PCT;
      `OFFSEL_HIGH: mult = `OFF_MULT_2PCT;
      default:      mult = `OFF_MULT_4PCT;
    endcase
    prod = on_ticks * mult;
    return prod[15:0];
  endfunction

  // Second synchroniser stage only; the first stage feeds nothing else
  assign rly_s   = s_r.sync2[3:0];
  assign sw_s    = s_r.sync2[7:4];
  assign oc_s    = s_r.sync2[11:8];
  assign openl_s = s_r.sync2[15:12];
  assign near_s  = s_r.sync2[19:16];
  assign uv_s    = s_r.sync2[20];

  // Zero in the field stands for an unprogrammed timing input
  assign to_lim  = (s_r.to_set == 8'h00) ? `TO_DEFAULT_TICKS : {8'h00, s_r.to_set};
  assign off_lim = off_ticks(s_r.off_sel, to_lim);

  // APB answers in the access cycle; no wait states needed
  assign addr_ok = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  assign prdata      = s_r.prdata;
  assign gate_enable = s_r.gate;
  assign relay_drive = s_r.relay_drv;
  assign port_status = s_r.status;
  assign fault_n     = s_r.fault_n;

  // Per-port status terms from current state
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      power_good[i] = sw_s[i] && (s_r.ports[i].sw == SW_ON) && near_s[i] && !uv_s && !oc_s[i]
                      && rly_s[i] && (s_r.ports[i].rly == RLY_READY);
      open_load_latched[i] = (s_r.ports[i].sw == SW_OPEN);
      port_fault[i] = (s_r.ports[i].sw == SW_OPEN)
                      || ((s_r.ports[i].sw == SW_OCOFF) && (s_r.retry_en || !s_r.ports[i].cleared));
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    port_type p;
    port_type np;
    logic     run_ok;
    logic     fall;
    p      = '0;
    np     = '0;
    run_ok = 1'b0;
    fall   = 1'b0;
    s_nxt  = s_r;

    // Two-flop synchronisers for every pin input
    s_nxt.sync1 = {supply_low_lockout, output_near_supply, open_load_detect, overcurrent,
                   switch_request, relay_request};
    s_nxt.sync2 = s_r.sync1;

    // Shared timebase tick
    if (s_r.tick_cnt == 14'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = 14'h0000;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 14'h0001;
      s_nxt.tick     = 1'b0;
    end

    // Register writes take effect in the access phase
    if (psel && penable && pwrite && (paddr == `ADDR_CTRL)) begin
      s_nxt.stat_sel = pwdata[`CTRL_STATSEL_BIT];
      s_nxt.open_en  = pwdata[`CTRL_OPENEN_BIT];
      s_nxt.retry_en = pwdata[`CTRL_RETRY_BIT];
      s_nxt.off_sel  = pwdata[`CTRL_OFFSEL_MSB:`CTRL_OFFSEL_LSB];
      s_nxt.to_set   = pwdata[`CTRL_TO_MSB:`CTRL_TO_LSB];
    end

    // Read data captured in the setup phase so it leaves a flop
    if (psel && !penable) begin
      if (paddr == `ADDR_CTRL) begin
        s_nxt.prdata = {16'h0000, s_r.to_set, 3'h0, s_r.off_sel, s_r.retry_en, s_r.open_en, s_r.stat_sel};
      end else if (paddr == `ADDR_STATUS) begin
        s_nxt.prdata = {8'h00, s_r.gate, s_r.relay_drv, 2'h0, uv_s, !s_r.fault_n,
                        port_fault, open_load_latched, power_good};
      end else begin
        s_nxt.prdata = 32'h0000_0000;
      end
    end

    // Ports run side by side, each on its own record
    for (int i = 0; i < 4; i++) begin
      p  = s_r.ports[i];
      np = p;

      // Relay sequencing
      if (uv_s) begin
        np.rly     = RLY_IDLE;
        np.rly_cnt = 9'h000;
      end else begin
        case (p.rly)
          RLY_IDLE: begin
            if (rly_s[i]) begin
              np.rly     = RLY_ARM;
              np.rly_cnt = 9'h000;
            end
          end
          RLY_ARM: begin
            if (!rly_s[i]) begin
              np.rly     = RLY_DROP;
              np.rly_cnt = 9'h000;
            end else if (s_r.tick) begin
              if (p.rly_cnt == `TON_DEL_TICKS - 9'h001) begin
                np.rly = RLY_READY;
              end else begin
                np.rly_cnt = p.rly_cnt + 9'h001;
              end
            end
          end
          RLY_READY: begin
            if (!rly_s[i]) begin
              np.rly     = RLY_DROP;
              np.rly_cnt = 9'h000;
            end
          end
          RLY_DROP: begin
            if (rly_s[i]) begin
              np.rly     = RLY_ARM;
              np.rly_cnt = 9'h000;
            end else if (s_r.tick) begin
              if (p.rly_cnt == `TOFF_DEL_TICKS - 9'h001) begin
                np.rly = RLY_IDLE;
              end else begin
                np.rly_cnt = p.rly_cnt + 9'h001;
              end
            end
          end
          default: begin
            np.rly = RLY_IDLE;
          end
        endcase
      end

      // Switch control; relay must be settled and the request still high
      run_ok      = rly_s[i] && (p.rly == RLY_READY) && !uv_s;
      fall        = p.sw_req_q && !sw_s[i];
      np.sw_req_q = sw_s[i];
      case (p.sw)
        SW_OFF: begin
          if (run_ok && sw_s[i]) begin
            np.sw       = SW_ON;
            np.sw_cnt   = 16'h0000;
            np.open_cnt = 14'h0000;
          end
        end
        SW_ON: begin
          if (!run_ok || !sw_s[i]) begin
            np.sw = SW_OFF;
          end else if (oc_s[i]) begin
            if (s_r.tick) begin
              if (p.sw_cnt >= to_lim - 16'h0001) begin
                np.sw      = SW_OCOFF;
                np.sw_cnt  = 16'h0000;
                np.cleared = 1'b0;
              end else begin
                np.sw_cnt = p.sw_cnt + 16'h0001;
              end
            end
          end else begin
            np.sw_cnt = 16'h0000;
            // Delay starts the first time the port looks good and keeps running until it holds at OPEN_DEL_TICKS
            if (s_r.tick && (near_s[i] || p.open_cnt != 14'h0000) && p.open_cnt != `OPEN_DEL_TICKS) begin
              np.open_cnt = p.open_cnt + 14'h0001;
            end
            if (s_r.open_en && (p.open_cnt == `OPEN_DEL_TICKS) && openl_s[i]) begin
              np.sw = SW_OPEN;
            end
          end
        end
        SW_OCOFF: begin
          if (fall) begin
            np.cleared = 1'b1;
          end
          if (s_r.tick && p.sw_cnt < off_lim) begin
            np.sw_cnt = p.sw_cnt + 16'h0001;
          end
          // Minimum off-time holds even after a manual clear
          if ((p.sw_cnt >= off_lim) && (s_r.retry_en || p.cleared || fall)) begin
            np.sw = SW_OFF;
          end
        end
        SW_OPEN: begin
          if (!sw_s[i]) begin
            np.sw = SW_OFF;
          end
        end
        default: begin
          np.sw = SW_OFF;
        end
      endcase

      s_nxt.ports[i]     = np;
      s_nxt.gate[i]      = (np.sw == SW_ON);
      s_nxt.relay_drv[i] = (np.rly != RLY_IDLE) ^ RELAY_ACTIVE_LOW;
      s_nxt.status[i]    = s_r.stat_sel ? power_good[i] : open_load_latched[i];
    end

    s_nxt.fault_n = !(|port_fault);
  end

  // Single state register; relay outputs reset to their inactive level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.relay_drv <= {4{RELAY_ACTIVE_LOW}};
      s_r.fault_n   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Checks on port 0, on the shared fault output, and on every port's gate and relay under lockout
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fault_any_port: assert property (|port_fault |=> !fault_n)
    else $error("fault output not low while a port is faulted");
  a_fault_open_latch: assert property ((s_r.ports[0].sw == SW_OPEN) |=> !fault_n)
    else $error("fault output not low during open-load latch");
  a_fault_latch_off: assert property ((s_r.ports[0].sw == SW_OCOFF && !s_r.retry_en && !s_r.ports[0].cleared)
    |=> !fault_n) else $error("fault output released before request fell");
  a_pg_needs_on: assert property (power_good[0] |-> (gate_enable[0] && !uv_s && !oc_s[0] && sw_s[0]))
    else $error("power-good set without its conditions");
  a_pg_drop_oc: assert property (oc_s[0] |-> !power_good[0])
    else $error("power-good high while current limiting");
  a_ol_status: assert property (open_load_latched[0] == (s_r.ports[0].sw == SW_OPEN))
    else $error("open-load status out of step with latch");
  a_status_mux: assert property (##1 (port_status[0] == ($past(s_r.stat_sel) ? $past(power_good[0])
    : $past(open_load_latched[0])))) else $error("status output wrongly routed");
  a_open_disabled: assert property ((s_r.ports[0].sw == SW_ON && !s_r.open_en) |=>
    (s_r.ports[0].sw != SW_OPEN)) else $error("open latch while detector disabled");
  a_gate_needs_relay: assert property (gate_enable[0] |-> (s_r.ports[0].rly == RLY_READY))
    else $error("gate on without settled relay");
  a_uv_all_off: assert property (uv_s |=> ##1 (gate_enable == 4'h0 && relay_drive == {4{RELAY_ACTIVE_LOW}}))
    else $error("switch or relay on under lockout");
  a_open_release: assert property ((s_r.ports[0].sw == SW_OPEN && !sw_s[0]) |=> (s_r.ports[0].sw == SW_OFF))
    else $error("open latch not reset by low request");
  a_tick_single: assert property (s_r.tick |=> !s_r.tick)
    else $error("tick longer than one cycle");
  a_relay_drop_keep: assert property ($rose(s_r.ports[0].rly == RLY_DROP) |-> ##1 !gate_enable[0]
    ##0 (relay_drive[0] != RELAY_ACTIVE_LOW)) else $error("relay dropped with switch");

  c_overcurrent_off: cover property ($rose(s_r.ports[0].sw == SW_OCOFF));
  c_open_latch:      cover property ($rose(s_r.ports[0].sw == SW_OPEN));
  c_power_good:      cover property ($rose(power_good[0]));
  c_retry_on:        cover property ((s_r.ports[0].sw == SW_OCOFF) ##1 (s_r.ports[0].sw == SW_OFF));

endmodule

// >>> dv/host_port_model.sv
/*
  Host-side partner: drives the relay and switch requests of each port and
  stands in for the overcurrent and near-supply comparators, following the gate it is given.
  Assumes one clock, async active-low reset, and commands from the bench.
*/
`timescale 1ns/1ps
module host_port_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] relay_cmd,
  input  wire logic [3:0] switch_cmd,
  input  wire logic [3:0] short_cmd,
  input  wire logic [3:0] gate_enable,
  output logic      [3:0] relay_request,
  output logic      [3:0] switch_request,
  output logic      [3:0] overcurrent,
  output logic      [3:0] output_near_supply
);
  // Pins move just after an edge; a shorted load never reaches full supply
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_request      <= 4'h0;
      switch_request     <= 4'h0;
      overcurrent        <= 4'h0;
      output_near_supply <= 4'h0;
    end else begin
      relay_request      <= relay_cmd;
      switch_request     <= switch_cmd & relay_cmd;
      overcurrent        <= short_cmd & gate_enable;
      output_near_supply <= gate_enable & ~short_cmd;
    end
  end
endmodule

// >>> dv/quad_hot_swap_port_control_test.sv
/*
  Self-checking bench for the quad hot-swap port controller.
  Assumes the host model beside it and a timebase shortened to 10 clocks a tick.
*/
`timescale 1ns/1ps
`include "hsc_defines.svh"
module quad_hot_swap_port_control_test;
  localparam int TK = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_n, lockout;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  relay_cmd, switch_cmd, short_cmd, relay_request, switch_request;
  logic [3:0]  overcurrent, near_supply, gate_enable, relay_drive, port_status, open_cmd;
  logic [33:0] bus_q[$];
  logic [3:0]  gate_q[$];
  logic [33:0] note;
  int          miscompares, compares, seed, n, i;
  int          mult[3]  = '{99, 49, 24};
  logic [1:0]  code[3]  = '{2'h0, 2'h1, 2'h3};

  quad_hot_swap_port_control #(.TICK_CYCLES(TK), .RELAY_ACTIVE_LOW(1'b1)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .relay_request(relay_request), .switch_request(switch_request), .overcurrent(overcurrent),
    .open_load_detect(open_cmd), .output_near_supply(near_supply), .supply_low_lockout(lockout),
    .gate_enable(gate_enable), .relay_drive(relay_drive), .port_status(port_status),
    .fault_n(fault_n));
  host_port_model host (
    .pclk(pclk), .presetn(presetn), .relay_cmd(relay_cmd), .switch_cmd(switch_cmd),
    .short_cmd(short_cmd), .gate_enable(gate_enable), .relay_request(relay_request),
    .switch_request(switch_request), .overcurrent(overcurrent), .output_near_supply(near_supply));

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer; the note is queued first so the monitor finds it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    bus_q.push_back({wr, e});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Polls port 0 gate; a timeout shows up as an out-of-range count
  task automatic wait_gate(input logic v, input int lim, output int c);
    c = 0;
    while (gate_enable[0] !== v && c < lim) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // Bus monitor: error flag always, data only on reads
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready) begin
      note = bus_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (!note[33]) check("prdata", prdata, note[31:0]);
    end
  end

  // Every gate change must have been announced by the driver
  always @(gate_enable) begin
    if (presetn === 1'b1) check("gate_enable", {28'h0, gate_enable}, {28'h0, gate_q.pop_front()});
  end

  // Watchdog sized well above the roughly 25k cycles the run needs
  initial begin
    #600000;
    miscompares++;
    summarize();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; lockout = 1'b0; seed = 70;
    relay_cmd = 4'h0; switch_cmd = 4'h0; short_cmd = 4'h0;
    // Random open-load comparator levels; the 900ms arming delay is never reached here
    open_cmd = 4'($random(seed));
    cyc(10);
    presetn <= 1'b1;
    check("relay reset", {28'h0, relay_drive}, 32'hF);
    check("fault reset", {31'h0, fault_n}, 32'h1);
    apb(1'b0, `ADDR_STATUS, 32'h0, {1'b0, 32'h000F_0000});
    rv = $random(seed) & 32'h0000_FF1F;
    apb(1'b1, `ADDR_CTRL, rv, 33'h0);
    apb(1'b0, `ADDR_CTRL, 32'h0, {1'b0, rv});
    apb(1'b1, `ADDR_STATUS, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0, {1'b0, 32'h000F_0000});
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, {1'b1, 32'h0});
    apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
    apb(1'b1, `ADDR_CTRL, 32'h0000_0001, 33'h0);
    // Port 1 relay alone, then port 0 relay and switch together
    relay_cmd <= 4'h2;
    cyc(6);
    check("relay p1", {28'h0, relay_drive}, 32'hD);
    gate_q.push_back(4'h1);
    relay_cmd  <= 4'h3;
    switch_cmd <= 4'h1;
    cyc(6);
    check("relay p0", {28'h0, relay_drive}, 32'hC);
    wait_gate(1'b1, 3000, n);
    check("turn-on delay", 32'(n inside {[2530:2580]}), 32'h1);
    cyc(8);
    check("power good", {28'h0, port_status}, 32'h1);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0000, 33'h0);
    cyc(4);
    check("open status", {28'h0, port_status}, 32'h0);
    // Retry at 4 % with the default overcurrent time
    apb(1'b1, `ADDR_CTRL, 32'h0000_0015, 33'h0);
    short_cmd <= 4'h1;
    cyc(8);
    check("pg in limit", {28'h0, port_status}, 32'h0);
    gate_q.push_back(4'h0);
    wait_gate(1'b0, 1000, n);
    check("default oc time", 32'(n inside {[600:660]}), 32'h1);
    cyc(3);
    check("fault retry", {31'h0, fault_n}, 32'h0);
    gate_q.push_back(4'h1);
    wait_gate(1'b1, 16000, n);
    short_cmd <= 4'h0;
    check("off 4pct", 32'(n inside {[15330:15420]}), 32'h1);
    cyc(6);
    check("fault cleared", {31'h0, fault_n}, 32'h1);
    // Each remaining duty code with a two-tick overcurrent time
    for (i = 0; i < 3; i++) begin
      apb(1'b1, `ADDR_CTRL, {16'h0, 8'h02, 3'h0, code[i], 3'h5}, 33'h0);
      short_cmd <= 4'h1;
      gate_q.push_back(4'h0);
      wait_gate(1'b0, 100, n);
      gate_q.push_back(4'h1);
      wait_gate(1'b1, 2200, n);
      short_cmd <= 4'h0;
      check("off period", 32'(n inside {[2*mult[i]*TK-15:2*mult[i]*TK+25]}), 32'h1);
      cyc(40);
    end
    // Latch-off: no retry until the switch request drops
    apb(1'b1, `ADDR_CTRL, 32'h0000_0200, 33'h0);
    short_cmd <= 4'h1;
    gate_q.push_back(4'h0);
    wait_gate(1'b0, 100, n);
    short_cmd <= 4'h0;
    cyc(2100);
    check("no retry", {31'h0, gate_enable[0]}, 32'h0);
    check("fault latched", {31'h0, fault_n}, 32'h0);
    switch_cmd <= 4'h0;
    cyc(6);
    check("latch cleared", {31'h0, fault_n}, 32'h1);
    switch_cmd <= 4'h1;
    gate_q.push_back(4'h1);
    wait_gate(1'b1, 100, n);
    check("restart", 32'(n < 100), 32'h1);
    // Relay drop: gate at once, relay after the release delay
    relay_cmd <= 4'h2;
    gate_q.push_back(4'h0);
    wait_gate(1'b0, 10, n);
    check("gate drop", 32'(n < 10), 32'h1);
    n = 0;
    while (relay_drive[0] !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("relay delay", 32'(n inside {[305:330]}), 32'h1);
    check("p1 untouched", {31'h0, relay_drive[1]}, 32'h0);
    // Lockout shuts every relay
    lockout <= 1'b1;
    cyc(6);
    check("lockout relay", {28'h0, relay_drive}, 32'hF);
    summarize();
  end
endmodule
